/* src/pos_regs.svh */
// Purpose: Constants of the output supervisor: enable cap table, thresholds, timing.
// Assumes: Voltages in millivolts, 13-bit codes; clk_sys at 250 MHz.
// Notes: Percent thresholds are in tenths of a percent; OV, UV and maximum of nominal, power-good of set-point.
// Operation
// - Clamp any requested set-point to 110 percent of strapped nominal.
// - While enabled, cap increases by lookup on set-point at enable.
// - While disabled, only the strap maximum limits a new set-point.
// - Over-voltage threshold defaults to 15 percent above nominal, reconfigurable.
// - Over-voltage response: shutdown with retry count, or crowbar until restart; code releases crowbar once over-voltage clears.
// - Default shutdown on over-voltage, auto re-enable once fault gone.
// - With external sync clock, only immediate shutdown is allowed.
// - Under-voltage threshold defaults to 15 percent below nominal, reconfigurable.
// - Power-good status bit only when in tolerance and no fault.
// - Power-good pin active high, open-drain default, push-pull when configured.
// - Power-good rises above 90 percent, falls below 85 percent, configurable.
// - Power-good asserts after configurable delay, 10 ms default.
// - With calibration enabled, power-good asserts right after calibration done.
// - Switching frequency 320 kHz default, 200 to 640 kHz accepted.
// - Internal clock default; sync pin as master output or slave input.
// - Up to 16 phase positions, only while synchronised to common clock; code also spreads phases while current sharing is on, even on internal clock.
// - Slave rail member trims voltage to match master current, max 7 members.
// - All members active until power-good; add or drop only afterwards.
// - Dropped reference passes to lowest-position remaining active member.
// - On member count change, phase position follows order among active members.
// - After rail fault shutdown, all members restart together once cleared.
// - Strap is sampled only at start-up.
`ifndef POS_REGS_SVH
`define POS_REGS_SVH
`define POS_VMAX_PCT 11'd1100
`define POS_OV_DEF_PCT 11'd1150
`define POS_UV_DEF_PCT 11'd850
`define POS_PG_ON_DEF_PCT 11'd900
`define POS_PG_OFF_DEF_PCT 11'd850
`define POS_PCT_DIV 24'd1000
`define POS_FSW_DEF_KHZ 10'd320
`define POS_FSW_MIN_KHZ 10'd200
`define POS_FSW_MAX_KHZ 10'd640
`define POS_PG_DLY_DEF_MS 16'd10
`define POS_CLK_KHZ 32'd250000
`define POS_MAX_MEMBERS 3'd7
`define POS_PHASES 5'd16
`define POS_BIN0 13'd988
`define POS_BIN1 13'd1383
`define POS_BIN2 13'd1975
`define POS_BIN3 13'd2398
`define POS_BIN4 13'd2963
`define POS_CAP0 13'd1200
`define POS_CAP1 13'd1700
`define POS_CAP2 13'd2500
`define POS_CAP3 13'd2970
`define POS_CAP4 13'd3680
`define POS_CAP5 13'd4650
`endif

/* src/pos_pkg.sv */
// Purpose: Types shared by the output supervisor files.
// Assumes: Millivolt codes of 13 bits.
// Notes: Thresholds are tenths of a percent; OV and UV of nominal, power-good of set-point.
package pos_pkg;
  typedef logic [12:0] pos_mv_t;
  typedef enum logic [1:0] {POS_OV_SHUTDOWN_RETRY, POS_OV_CROWBAR, POS_OV_SHUTDOWN_AUTO} pos_ovr_e;
  typedef enum logic [1:0] {POS_SYNC_INTERNAL, POS_SYNC_OUTPUT, POS_SYNC_INPUT} pos_sync_e;
  typedef struct packed {
    logic [10:0] ov_pct;
    logic [10:0] uv_pct;
    logic [10:0] pg_on_pct;
    logic [10:0] pg_off_pct;
    logic [15:0] pg_delay_ms;
    pos_ovr_e ov_resp;
    logic [3:0] ov_retries;
    logic calib_en;
    logic pg_push_pull;
    logic [9:0] fsw_khz;
    pos_sync_e sync_mode;
    logic phase_spread_en;
    logic [3:0] phase_base;
  } pos_cfg_s;
  typedef struct packed {
    logic output_good_flag;
    logic ov_fault;
    logic uv_fault;
    logic off_by_fault;
    logic crowbar;
    logic [3:0] retries_left;
  } pos_stat_s;
endpackage : pos_pkg

/* src/pos_pg_timer.sv */
// Purpose: Power-good delay counter in milliseconds.
// Assumes: Conditions come from clk_sys logic.
// Notes: Any drop of the conditions restarts the wait.
`timescale 1ns/10ps
`include "pos_regs.svh"
module pos_pg_timer import pos_pkg::*; #(
  parameter logic [31:0] CYC_PER_MS = `POS_CLK_KHZ
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic cond_ok,
  input wire logic skip_wait,
  input wire logic [15:0] delay_ms,
  output logic good
);
  logic [31:0] cyc_r;
  logic [15:0] ms_r;
  logic good_r;
  wire logic ms_tick = (cyc_r == CYC_PER_MS - 32'd1);
  wire logic done = skip_wait || (ms_r >= delay_ms);
  always_ff @(posedge clk_sys) begin
    if (reset || !cond_ok) begin
      cyc_r <= 32'h0;
      ms_r <= 16'h0;
      good_r <= 1'b0;
    end else begin
      cyc_r <= ms_tick ? 32'h0 : cyc_r + 32'd1;
      if (ms_tick && !done) ms_r <= ms_r + 16'd1;
      good_r <= done;
    end
  end
  assign good = good_r;
endmodule : pos_pg_timer

/* src/pos_rail_mgr.sv */
// Purpose: Current-sharing rail membership, reference and phase slot.
// Assumes: Member positions 0..6; commands are one-cycle pulses.
// Notes: Membership edits are refused before rail power-good.
`timescale 1ns/10ps
`include "pos_regs.svh"
module pos_rail_mgr import pos_pkg::*; (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic [2:0] member_count,
  input wire logic [2:0] my_position,
  input wire logic rail_good,
  input wire logic cmd_valid,
  input wire logic cmd_add,
  input wire logic [2:0] cmd_member,
  output logic [6:0] active_r,
  output logic [2:0] ref_member_r,
  output logic [3:0] rank_r,
  output logic [3:0] active_count_r
);
  logic [6:0] mask;
  logic [6:0] act_nxt;
  logic [2:0] low_pos;
  logic [3:0] rank_nxt;
  logic [3:0] cnt_nxt;
  always_comb begin
    mask = 7'h0;
    for (int i = 0; i < 7; i++) if (i < member_count) mask[i] = 1'b1;
  end
  wire logic cmd_ok = cmd_valid && rail_good && (cmd_member < member_count);
  always_comb begin
    act_nxt = active_r;
    if (!rail_good) act_nxt = mask;
    else if (cmd_ok) act_nxt[cmd_member] = cmd_add;
    low_pos = 3'h0;
    for (int i = 6; i >= 0; i--) if (act_nxt[i]) low_pos = 3'(i);
    rank_nxt = 4'h0;
    cnt_nxt = 4'h0;
    for (int i = 0; i < 7; i++) begin
      if (act_nxt[i]) cnt_nxt = cnt_nxt + 4'd1;
      if (act_nxt[i] && 3'(i) < my_position) rank_nxt = rank_nxt + 4'd1;
    end
  end
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      active_r <= 7'h0;
      ref_member_r <= 3'h0;
      rank_r <= 4'h0;
      active_count_r <= 4'h0;
    end else begin
      active_r <= act_nxt;
      if (!act_nxt[ref_member_r] || !rail_good) ref_member_r <= low_pos;
      rank_r <= rank_nxt;
      active_count_r <= cnt_nxt;
    end
  end
endmodule : pos_rail_mgr

/* src/pos_supervisor.sv */
// Purpose: Output supervisor: set-point limits, OV/UV, power-good, sync, rail.
// Assumes: Voltage codes in millivolts from the converter's ADC path.
// Notes: Host configuration arrives as plain ports; no register bus.
`timescale 1ns/10ps
`include "pos_regs.svh"
module pos_supervisor import pos_pkg::*; #(
  parameter logic [31:0] CYC_PER_MS = `POS_CLK_KHZ
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic startup,
  input wire pos_mv_t strap_setpoint_resistor,
  input wire logic output_enable,
  input wire logic setpoint_wr,
  input wire pos_mv_t setpoint_req,
  input wire pos_mv_t vout_mv,
  input wire pos_cfg_s cfg,
  input wire logic calib_done,
  input wire logic cs_enable,
  input wire logic cs_is_master,
  input wire logic [2:0] cs_member_count,
  input wire logic [2:0] cs_my_position,
  input wire logic [11:0] cs_master_current,
  input wire logic [11:0] cs_my_current,
  input wire logic rail_fault,
  input wire logic rail_fault_clear,
  input wire logic member_cmd_valid,
  input wire logic member_cmd_add,
  input wire logic [2:0] member_cmd_member,
  input wire logic sync_pin_in,
  output logic sync_pin_out,
  output logic sync_pin_oe,
  output logic output_good_pin_out,
  output logic output_good_pin_oe,
  output pos_mv_t setpoint_active,
  output logic [9:0] fsw_khz_active,
  output logic use_external_clock,
  output logic [3:0] phase_slot,
  output logic [6:0] active_members,
  output logic [2:0] reference_member,
  output logic power_stage_on,
  output logic low_side_hold,
  output logic [12:0] cs_trim,
  output pos_stat_s status
);
  // ================================================================
  // Helpers
  function automatic pos_mv_t pct_of(pos_mv_t nom, logic [10:0] pct);
    logic [23:0] prod;
    prod = 24'(nom) * 24'(pct);
    return 13'(prod / `POS_PCT_DIV);
  endfunction : pct_of

  function automatic pos_mv_t enable_cap(pos_mv_t v);
    if (v < `POS_BIN0) return `POS_CAP0;
    else if (v < `POS_BIN1) return `POS_CAP1;
    else if (v < `POS_BIN2) return `POS_CAP2;
    else if (v < `POS_BIN3) return `POS_CAP3;
    else if (v < `POS_BIN4) return `POS_CAP4;
    else return `POS_CAP5;
  endfunction : enable_cap

  function automatic pos_mv_t min_mv(pos_mv_t a, pos_mv_t b);
    return (a < b) ? a : b;
  endfunction : min_mv

  // ================================================================
  // Strap capture and set-point
  pos_mv_t nominal_r;
  logic strap_taken_r;
  pos_mv_t setpoint_r;
  pos_mv_t setpoint_nxt;
  pos_mv_t en_point_r;
  logic en_d_r;
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      nominal_r <= 13'h0;
      strap_taken_r <= 1'b0;
    end else if (startup && !strap_taken_r) begin
      nominal_r <= strap_setpoint_resistor;
      strap_taken_r <= 1'b1;
    end
  end
  wire pos_mv_t strap_max = pct_of(nominal_r, `POS_VMAX_PCT);
  wire pos_mv_t run_cap = enable_cap(en_point_r);
  wire pos_mv_t limit_now = output_enable ? min_mv(strap_max, run_cap) : strap_max;
  wire logic en_rise = output_enable && !en_d_r;
  always_comb begin
    setpoint_nxt = setpoint_r;
    if (startup && !strap_taken_r) setpoint_nxt = strap_setpoint_resistor;
    else if (setpoint_wr) setpoint_nxt = min_mv(setpoint_req, limit_now);
  end
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      setpoint_r <= 13'h0;
      en_point_r <= 13'h0;
      en_d_r <= 1'b0;
    end else begin
      setpoint_r <= setpoint_nxt;
      en_d_r <= output_enable;
      if (en_rise) en_point_r <= setpoint_r;
    end
  end

  // ================================================================
  // Thresholds
  wire pos_mv_t ov_lvl = pct_of(nominal_r, cfg.ov_pct);
  wire pos_mv_t uv_lvl = pct_of(nominal_r, cfg.uv_pct);
  wire pos_mv_t pg_on_lvl = pct_of(setpoint_r, cfg.pg_on_pct);
  wire pos_mv_t pg_off_lvl = pct_of(setpoint_r, cfg.pg_off_pct);
  logic pg_arm_r;
  logic uv_arm_r;
  wire logic ov_now = strap_taken_r && (vout_mv > ov_lvl);
  wire logic uv_now = power_stage_on && uv_arm_r && (vout_mv < uv_lvl);

  // ================================================================
  // Sync source and frequency
  logic [2:0] sync_sr_r;
  logic sync_seen_r;
  wire logic ext_clk = (cfg.sync_mode == POS_SYNC_INPUT);
  wire logic fsw_legal = (cfg.fsw_khz >= `POS_FSW_MIN_KHZ) && (cfg.fsw_khz <= `POS_FSW_MAX_KHZ);
  logic [9:0] fsw_r;
  logic [15:0] sync_div_r;
  wire logic [15:0] half_period = 16'(`POS_CLK_KHZ / (32'(fsw_r) * 32'd2));
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      sync_sr_r <= 3'h0;
      sync_seen_r <= 1'b0;
      fsw_r <= `POS_FSW_DEF_KHZ;
      sync_div_r <= 16'h0;
      sync_pin_out <= 1'b0;
    end else begin
      sync_sr_r <= {sync_sr_r[1:0], sync_pin_in};
      if (sync_sr_r[1] != sync_sr_r[2]) sync_seen_r <= 1'b1;
      if (fsw_legal) fsw_r <= cfg.fsw_khz;
      if (sync_div_r + 16'd1 >= half_period) begin
        sync_div_r <= 16'h0;
        sync_pin_out <= !sync_pin_out;
      end else begin
        sync_div_r <= sync_div_r + 16'd1;
      end
    end
  end
  assign sync_pin_oe = (cfg.sync_mode == POS_SYNC_OUTPUT);
  assign use_external_clock = ext_clk;
  assign fsw_khz_active = fsw_r;
  wire logic synced = (cfg.sync_mode == POS_SYNC_OUTPUT) || (ext_clk && sync_seen_r) || cs_enable;

  // ================================================================
  // Over-voltage response
  typedef enum logic [1:0] {POS_RUN, POS_SHUT, POS_CROW, POS_LATCH} pos_ov_st_e;
  pos_ov_st_e ov_st_r;
  logic [3:0] retry_r;
  logic rail_hold_r;
  wire pos_ovr_e resp = ext_clk ? POS_OV_SHUTDOWN_AUTO : cfg.ov_resp;
  wire logic fault_now = ov_now || uv_now || rail_fault;
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      ov_st_r <= POS_RUN;
      retry_r <= 4'h0;
      rail_hold_r <= 1'b0;
    end else begin
      if (rail_fault && cs_enable) rail_hold_r <= 1'b1;
      else if (rail_fault_clear) rail_hold_r <= 1'b0;
      unique case (ov_st_r)
        POS_RUN: begin
          if (ov_now) begin
            ov_st_r <= (resp == POS_OV_CROWBAR) ? POS_CROW : POS_SHUT;
            retry_r <= (resp == POS_OV_SHUTDOWN_RETRY) ? cfg.ov_retries : 4'h0;
          end
        end
        POS_SHUT: begin
          if (!ov_now && !rail_hold_r) begin
            if (resp != POS_OV_SHUTDOWN_RETRY) ov_st_r <= POS_RUN;
            else if (retry_r != 4'h0) begin
              retry_r <= retry_r - 4'd1;
              ov_st_r <= POS_RUN;
            end else ov_st_r <= POS_LATCH;
          end
        end
        POS_CROW: begin
          if (ext_clk) ov_st_r <= POS_SHUT;
          else if (!ov_now && !rail_hold_r) ov_st_r <= POS_RUN;
        end
        POS_LATCH: if (!output_enable) ov_st_r <= POS_RUN;
      endcase
    end
  end
  assign power_stage_on = output_enable && (ov_st_r == POS_RUN) && !rail_hold_r;
  assign low_side_hold = (ov_st_r == POS_CROW) && !ext_clk;

  // ================================================================
  // Power-good with hysteresis
  // UV stays armed after good, so a sag keeps being reported
  always_ff @(posedge clk_sys) begin
    if (reset || !power_stage_on) uv_arm_r <= 1'b0;
    else if (pg_arm_r) uv_arm_r <= 1'b1;
  end
  logic pg_good;
  always_ff @(posedge clk_sys) begin
    if (reset) pg_arm_r <= 1'b0;
    else if (!power_stage_on || vout_mv < pg_off_lvl) pg_arm_r <= 1'b0;
    else if (vout_mv > pg_on_lvl) pg_arm_r <= 1'b1;
  end
  wire logic pg_cond = pg_arm_r && power_stage_on && !fault_now;
  pos_pg_timer #(.CYC_PER_MS(CYC_PER_MS)) u_pg (
    .clk_sys(clk_sys),
    .reset(reset),
    .cond_ok(pg_cond && (!cfg.calib_en || calib_done)),
    .skip_wait(cfg.calib_en && calib_done),
    .delay_ms(cfg.pg_delay_ms),
    .good(pg_good)
  );
  wire logic pg_final = pg_good && pg_cond;
  assign output_good_pin_out = pg_final;
  assign output_good_pin_oe = cfg.pg_push_pull ? 1'b1 : !pg_final;

  // ================================================================
  // Rail membership and phase
  logic [3:0] rank;
  logic [3:0] act_cnt;
  pos_rail_mgr u_rail (
    .clk_sys(clk_sys),
    .reset(reset),
    .member_count(cs_enable ? cs_member_count : 3'd1),
    .my_position(cs_my_position),
    .rail_good(pg_final),
    .cmd_valid(member_cmd_valid && cs_enable),
    .cmd_add(member_cmd_add),
    .cmd_member(member_cmd_member),
    .active_r(active_members),
    .ref_member_r(reference_member),
    .rank_r(rank),
    .active_count_r(act_cnt)
  );
  logic [3:0] phase_r;
  always_ff @(posedge clk_sys) begin
    if (reset) phase_r <= 4'h0;
    else if (!synced || !cfg.phase_spread_en) phase_r <= 4'h0;
    else phase_r <= cfg.phase_base + rank;
  end
  assign phase_slot = phase_r;

  // ================================================================
  // Current-share trim: slaves nudge toward master current
  logic [12:0] trim_r;
  wire logic is_slave = cs_enable && !cs_is_master && (cs_my_position < `POS_MAX_MEMBERS);
  always_ff @(posedge clk_sys) begin
    if (reset || !is_slave || !power_stage_on) trim_r <= 13'h0;
    else if (cs_my_current < cs_master_current && trim_r != 13'h0fff) trim_r <= trim_r + 13'd1;
    else if (cs_my_current > cs_master_current && trim_r != 13'h1001) trim_r <= trim_r - 13'd1;
  end
  assign cs_trim = trim_r;
  assign setpoint_active = setpoint_r;

  // ================================================================
  // Status
  always_ff @(posedge clk_sys) begin
    if (reset) status <= '0;
    else begin
      status.output_good_flag <= pg_final;
      status.ov_fault <= ov_now;
      status.uv_fault <= uv_now;
      status.off_by_fault <= (ov_st_r != POS_RUN) || rail_hold_r;
      status.crowbar <= low_side_hold;
      status.retries_left <= retry_r;
    end
  end
endmodule : pos_supervisor

/* tb/pos_sup_checker.sv */
// Purpose: Port-level assertions for the output supervisor.
// Assumes: Nominal is the strap value on the first startup cycle.
// Notes: Over-voltage trip keeps a 1 mV margin against rounding.
`timescale 1ns/10ps
`include "pos_regs.svh"
module pos_sup_checker import pos_pkg::*; (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic startup,
  input wire pos_mv_t strap_setpoint_resistor,
  input wire logic output_enable,
  input wire logic setpoint_wr,
  input wire pos_mv_t setpoint_req,
  input wire pos_mv_t vout_mv,
  input wire pos_cfg_s cfg,
  input wire logic cs_enable,
  input wire logic rail_fault,
  input wire logic member_cmd_valid,
  input wire logic sync_pin_oe,
  input wire logic output_good_pin_out,
  input wire logic output_good_pin_oe,
  input wire pos_mv_t setpoint_active,
  input wire logic [9:0] fsw_khz_active,
  input wire logic use_external_clock,
  input wire logic [3:0] phase_slot,
  input wire logic [6:0] active_members,
  input wire logic power_stage_on,
  input wire logic low_side_hold,
  input wire pos_stat_s status
);
  // ========
  // Strap capture
  logic seen_r;
  pos_mv_t nom_r;
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      seen_r <= 1'b0;
      nom_r <= 13'h0;
    end else if (startup && !seen_r) begin
      seen_r <= 1'b1;
      nom_r <= strap_setpoint_resistor;
    end
  end
  wire [23:0] max_x10 = 24'(nom_r) * 24'h00000b;
  wire [23:0] ov_lim = 24'(nom_r) * 24'(cfg.ov_pct) + 24'h0003e8;
  wire ov_hit = seen_r && (24'(vout_mv) * 24'h0003e8 > ov_lim);
  // ========
  // Properties
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);
  sequence s_fault2;
    (status.ov_fault || status.uv_fault) [*2];
  endsequence
  sequence s_no_sync;
    (cfg.sync_mode == POS_SYNC_INTERNAL && !cs_enable) [*3];
  endsequence
  property p_clamp;
    setpoint_wr && seen_r |=> 24'(setpoint_active) * 24'h00000a <= max_x10;
  endproperty
  property p_take_off;
    setpoint_wr && seen_r && !output_enable && 24'(setpoint_req) * 24'h00000a <= max_x10
      |=> setpoint_active == $past(setpoint_req);
  endproperty
  property p_ov_off;
    ov_hit |=> !power_stage_on;
  endproperty
  property p_ext_auto;
    use_external_clock |-> !low_side_hold;
  endproperty
  property p_pg_drive;
    output_good_pin_oe == (cfg.pg_push_pull || !output_good_pin_out);
  endproperty
  property p_refuse;
    member_cmd_valid && !output_good_pin_out && !status.output_good_flag
      |=> $stable(active_members);
  endproperty
  property p_fsw;
    fsw_khz_active >= `POS_FSW_MIN_KHZ && fsw_khz_active <= `POS_FSW_MAX_KHZ;
  endproperty
  property p_sync;
    use_external_clock == (cfg.sync_mode == POS_SYNC_INPUT)
      && sync_pin_oe == (cfg.sync_mode == POS_SYNC_OUTPUT);
  endproperty
  property p_phase;
    s_no_sync |-> phase_slot == 4'h0;
  endproperty
  property p_rail;
    rail_fault |=> !power_stage_on;
  endproperty
  property p_pg_fault;
    s_fault2 |-> !status.output_good_flag;
  endproperty
  a_clamp: assert property (p_clamp) else $error("set-point above strap maximum");
  a_take_off: assert property (p_take_off) else $error("disabled write not taken");
  a_ov_off: assert property (p_ov_off) else $error("stage on after over-voltage");
  a_ext_auto: assert property (p_ext_auto) else $error("crowbar with external clock");
  a_pg_drive: assert property (p_pg_drive) else $error("good pin drive mode wrong");
  a_refuse: assert property (p_refuse) else $error("member edit before good");
  a_fsw: assert property (p_fsw) else $error("frequency out of range");
  a_sync: assert property (p_sync) else $error("sync pin mode wrong");
  a_phase: assert property (p_phase) else $error("phase slot without sync");
  a_rail: assert property (p_rail) else $error("stage on during rail fault");
  a_pg_fault: assert property (p_pg_fault) else $error("good flag during fault");
endmodule : pos_sup_checker
bind pos_supervisor pos_sup_checker pos_sup_checker_i (.clk_sys, .reset, .startup,
  .strap_setpoint_resistor, .output_enable, .setpoint_wr, .setpoint_req, .vout_mv, .cfg,
  .cs_enable, .rail_fault, .member_cmd_valid, .sync_pin_oe, .output_good_pin_out,
  .output_good_pin_oe, .setpoint_active, .fsw_khz_active, .use_external_clock, .phase_slot,
  .active_members, .power_stage_on, .low_side_hold, .status);

/* tb/pos_stage_model.sv */
// Purpose: Power stage and load seen from the supervisor.
// Assumes: Output settles to the set-point one clock after the stage runs.
// Notes: Forcing stands for load faults; a held low side grounds the output.
`timescale 1ns/10ps
module pos_stage_model import pos_pkg::*; (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic power_stage_on,
  input wire logic low_side_hold,
  input wire pos_mv_t setpoint_active,
  input wire logic force_en,
  input wire pos_mv_t force_mv,
  output pos_mv_t vout_mv
);
  // ========
  // Output voltage
  // Fixed dead times assumed on shared rails
  pos_mv_t vout_r;
  wire pos_mv_t vout_nxt = force_en ? force_mv
    : (power_stage_on && !low_side_hold) ? setpoint_active : 13'h0;
  always_ff @(posedge clk_sys) begin
    if (reset) vout_r <= 13'h0;
    else vout_r <= vout_nxt;
  end
  assign vout_mv = vout_r;
endmodule : pos_stage_model

/* tb/pos_supervisor_test.sv */
// Purpose: Self-checking bench for the output supervisor.
// Assumes: CYC_PER_MS of 10, so one ms is ten clocks; strap 2000 mV.
// Notes: Good pin has a pull-up, so the line is high when released.
`timescale 1ns/10ps
`include "pos_regs.svh"
module pos_supervisor_test import pos_pkg::*;;
  logic clk_sys, reset, startup, output_enable, setpoint_wr, calib_done, cs_enable;
  logic rail_fault, rail_fault_clear, member_cmd_valid, member_cmd_add, sync_pin_in;
  logic force_en, sync_pin_out, sync_pin_oe, pg_out, pg_oe, use_ext, power_stage_on;
  logic low_side_hold, cs_is_master;
  logic [2:0] member_cmd_member, reference_member;
  pos_mv_t strap, setpoint_req, force_mv, vout_mv, setpoint_active, cs_trim;
  pos_cfg_s cfg;
  pos_stat_s status;
  logic [9:0] fsw;
  logic [3:0] phase_slot;
  logic [6:0] active_members;
  int miscompares, cmp_count, cyc_count, i;
  wire pg_line = pg_oe ? pg_out : 1'b1;
  pos_supervisor #(.CYC_PER_MS(32'h0000000a)) pos_supervisor_i (.clk_sys, .reset, .startup,
    .strap_setpoint_resistor(strap), .output_enable, .setpoint_wr, .setpoint_req, .vout_mv,
    .cfg, .calib_done, .cs_enable, .cs_is_master, .cs_member_count(3'h4),
    .cs_my_position(3'h2), .cs_master_current(12'h100), .cs_my_current(12'h0f0),
    .rail_fault, .rail_fault_clear, .member_cmd_valid, .member_cmd_add, .member_cmd_member,
    .sync_pin_in, .sync_pin_out, .sync_pin_oe, .output_good_pin_out(pg_out),
    .output_good_pin_oe(pg_oe), .setpoint_active, .fsw_khz_active(fsw),
    .use_external_clock(use_ext), .phase_slot, .active_members, .reference_member,
    .power_stage_on, .low_side_hold, .cs_trim, .status);
  pos_stage_model pos_stage_model_i (.clk_sys, .reset, .power_stage_on, .low_side_hold,
    .setpoint_active, .force_en, .force_mv, .vout_mv);
  // ========
  // Clock, sync input and timeout
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end
  always #12 sync_pin_in = ~sync_pin_in;
  always @(posedge clk_sys) begin
    cyc_count++;
    if (cyc_count == 32'h00000fa0) begin
      miscompares++;
      final_report();
    end
  end
  // ========
  // Shared tasks
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR time %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(negedge clk_sys);
  endtask : cyc
  task automatic ws(input pos_mv_t v, input pos_mv_t exp);
    cyc(1);
    setpoint_wr = 1'b1;
    setpoint_req = v;
    cyc(1);
    setpoint_wr = 1'b0;
    cyc(1);
    chk(setpoint_active, exp);
  endtask : ws
  task automatic mc(input logic add, input logic [2:0] m);
    cyc(1);
    member_cmd_valid = 1'b1;
    member_cmd_add = add;
    member_cmd_member = m;
    cyc(1);
    member_cmd_valid = 1'b0;
    cyc(4);
  endtask : mc
  task automatic final_report();
    $display("Comparisons %0d, mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : final_report
  // ========
  // Scenarios
  task automatic t_setpoint();
    chk(fsw, `POS_FSW_DEF_KHZ);
    chk(active_members, 7'h0f);
    mc(1'b0, 3'h1);
    chk(active_members, 7'h0f);
    ws(13'h3e8, 13'h3e8);
    output_enable = 1'b1;
    ws(13'h898, `POS_CAP1);
    output_enable = 1'b0;
    ws(13'h898, 13'h898);
    ws(13'hbb8, 13'h898);
    cyc(1);
    setpoint_wr = 1'b1;
    setpoint_req = 13'h3e8;
    ws(13'h7d0, 13'h7d0);
    strap = 13'h3e8;
    ws(13'h898, 13'h898);
    ws(13'h7d0, 13'h7d0);
  endtask : t_setpoint
  task automatic t_pg();
    output_enable = 1'b1;
    cyc(80);
    chk(pg_line, 1'b0);
    for (i = 0; i < 40 && pg_line !== 1'b1; i++) cyc(1);
    chk(pg_line, 1'b1);
    cyc(2);
    chk(status.output_good_flag, 1'b1);
    chk(pg_oe, 1'b0);
    cfg.pg_push_pull = 1'b1;
    cyc(1);
    chk(pg_oe, 1'b1);
    force_mv = 13'h6d6;
    force_en = 1'b1;
    cyc(5);
    chk(pg_line, 1'b1);
    force_mv = 13'h5dc;
    cyc(5);
    chk(pg_line, 1'b0);
    chk(status.uv_fault, 1'b1);
    chk(status.output_good_flag, 1'b0);
    cfg.calib_en = 1'b1;
    calib_done = 1'b1;
    force_en = 1'b0;
    cyc(10);
    chk(pg_line, 1'b1);
  endtask : t_pg
  task automatic t_rail();
    mc(1'b0, 3'h0);
    chk(active_members, 7'h0e);
    chk(reference_member, 3'h1);
    chk(phase_slot, 4'h1);
    mc(1'b1, 3'h0);
    chk(active_members, 7'h0f);
    chk(phase_slot, 4'h2);
    cs_is_master = 1'b0;
    cyc(3);
    chk(cs_trim, 13'h0003);
    cs_is_master = 1'b1;
  endtask : t_rail
  task automatic t_fault();
    force_mv = 13'h8e8;
    force_en = 1'b1;
    cyc(3);
    chk(power_stage_on, 1'b1);
    force_mv = 13'h960;
    cyc(3);
    chk(power_stage_on, 1'b0);
    chk(status.ov_fault, 1'b1);
    force_en = 1'b0;
    for (i = 0; i < 50 && power_stage_on !== 1'b1; i++) cyc(1);
    chk(power_stage_on, 1'b1);
    cfg.ov_resp = POS_OV_CROWBAR;
    force_en = 1'b1;
    cyc(3);
    chk(low_side_hold, 1'b1);
    cfg.sync_mode = POS_SYNC_INPUT;
    cyc(2);
    chk(low_side_hold, 1'b0);
    chk(power_stage_on, 1'b0);
    force_en = 1'b0;
    for (i = 0; i < 50 && power_stage_on !== 1'b1; i++) cyc(1);
    chk(power_stage_on, 1'b1);
    cfg.sync_mode = POS_SYNC_INTERNAL;
    cfg.ov_resp = POS_OV_SHUTDOWN_AUTO;
    rail_fault = 1'b1;
    cyc(3);
    chk(power_stage_on, 1'b0);
    rail_fault = 1'b0;
    cyc(5);
    chk(power_stage_on, 1'b0);
    rail_fault_clear = 1'b1;
    cyc(1);
    rail_fault_clear = 1'b0;
    for (i = 0; i < 20 && power_stage_on !== 1'b1; i++) cyc(1);
    chk(power_stage_on, 1'b1);
  endtask : t_fault
  task automatic t_clk();
    logic [9:0] fv [4] = '{10'h280, 10'h2bc, 10'h0c7, 10'h0c8};
    logic [9:0] fe [4] = '{10'h280, 10'h280, 10'h280, 10'h0c8};
    for (i = 0; i < 4; i++) begin
      cfg.fsw_khz = fv[i];
      cyc(3);
      chk(fsw, fe[i]);
    end
    for (i = 0; i < 3; i++) begin
      cfg.sync_mode = pos_sync_e'(i);
      cyc(2);
      chk(sync_pin_oe, i == 1);
      chk(use_ext, i == 2);
    end
    cs_enable = 1'b0;
    cfg.sync_mode = POS_SYNC_INTERNAL;
    cyc(4);
    chk(phase_slot, 4'h0);
  endtask : t_clk
  // ========
  // Main sequence
  initial begin
    {reset, startup, output_enable, setpoint_wr, calib_done, cs_enable, cs_is_master} = 7'h43;
    {rail_fault, rail_fault_clear, member_cmd_valid, member_cmd_add, force_en} = 5'h0;
    {member_cmd_member, setpoint_req, force_mv, sync_pin_in} = 30'h0;
    strap = 13'h7d0;
    cfg = '{ov_pct: `POS_OV_DEF_PCT, uv_pct: `POS_UV_DEF_PCT, pg_on_pct: `POS_PG_ON_DEF_PCT,
      pg_off_pct: `POS_PG_OFF_DEF_PCT, pg_delay_ms: `POS_PG_DLY_DEF_MS,
      ov_resp: POS_OV_SHUTDOWN_AUTO, ov_retries: 4'h3, calib_en: 1'b0, pg_push_pull: 1'b0,
      fsw_khz: `POS_FSW_DEF_KHZ, sync_mode: POS_SYNC_INTERNAL, phase_spread_en: 1'b1,
      phase_base: 4'h0};
    cyc(16);
    reset = 1'b0;
    startup = 1'b1;
    cyc(2);
    t_setpoint();
    t_pg();
    t_rail();
    t_fault();
    t_clk();
    final_report();
  end
endmodule : pos_supervisor_test
